// file: vmesb_pkg.sv
// Constants, encodings and carrier types of the VME slave with group broadcasting.
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package vmesb_pkg;
    // Register map of the local control port.
    localparam logic [31:0] EXT_MODE_ADDR = 32'hfe38_4003;
    localparam logic [31:0] BCAST_ON_ADDR = 32'hfe38_c009;
    localparam logic [31:0] BCAST_OFF_ADDR = 32'hfe38_c008;
    localparam logic [31:0] STATUS_ADDR = 32'hfe38_c00c;
    localparam logic [7:0] EXT_MODE_ON = 8'h0f;
    localparam logic [7:0] EXT_MODE_OFF = 8'h07;
    // Status register bit positions.
    localparam int ST_SLV_EN_BIT = 0;
    localparam int ST_BC_EN_BIT = 1;
    localparam int ST_GRP32_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_GRP_DRV_BIT = 4;
    // Reset values.
    localparam logic SLV_EN_RST = 1'b0;
    localparam logic BC_EN_RST = 1'b0;
    // Block transfer limits and address steps.
    localparam logic [8:0] MAX_BEATS = 9'h100;
    localparam logic [31:0] ADDR_STEP_D32 = 32'h0000_0004;
    localparam logic [31:0] ADDR_STEP_D64 = 32'h0000_0008;
    // Address modifiers of block cycles.
    localparam logic [5:0] AM_BLT_USR = 6'h0b;
    localparam logic [5:0] AM_BLT_SUP = 6'h0f;
    localparam logic [5:0] AM_MBLT_USR = 6'h08;
    localparam logic [5:0] AM_MBLT_SUP = 6'h0c;
    // Width of a local memory offset, enough for 32 MB.
    localparam int MEM_OFF_W = 25;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM = 2'b01,
        ST_GRP = 2'b11,
        ST_ACK = 2'b10
    } vmesb_state_t;

    // VME bus signals as seen by the slave, active-low strobes.
    typedef struct packed {
        logic as_b;
        logic ds_b;
        logic write_b;
        logic [5:0] am;
        logic [31:0] addr;
        logic [63:0] data;
    } vmesb_vme_t;

    // Request toward the local memory arbiter.
    typedef struct packed {
        logic req;
        logic we;
        logic wide;
        logic [MEM_OFF_W-1:0] addr;
        logic [63:0] wdata;
    } vmesb_mem_t;
endpackage : vmesb_pkg

// file: vmesb_win_dec.sv
// Window decoder for the own slave window and the broadcast group window.
`timescale 1ns/1ps
module vmesb_win_dec
    import vmesb_pkg::*;
(
    input wire logic [31:0] addr,
    input wire logic [31:22] slave_base,
    input wire logic win32,
    input wire logic grp32,
    input wire logic bc_en,
    input wire logic write,
    output logic slv_hit,
    output logic grp_hit,
    output logic [MEM_OFF_W-1:0] mem_off
);
    // -------------------------------------------------------------------------
    // Address compare
    // -------------------------------------------------------------------------
    // The own window uses the base bits down to its size; bits 27 to 24 give
    // its place inside the group region.
    always_comb
    begin
        if (win32)
        begin
            slv_hit = (addr[31:25] == slave_base[31:25]);
        end
        else
        begin
            slv_hit = (addr[31:24] == slave_base[31:24]);
        end
    end

    // Group region is the top nibble of the base and the group window is its
    // bottom 16 or 32 MB; only writes broadcast, and only when enabled.
    always_comb
    begin
        grp_hit = bc_en && write && (addr[31:28] == slave_base[31:28]);
        if (grp32)
        begin
            grp_hit = grp_hit && (addr[27:25] == 3'h0);
        end
        else
        begin
            grp_hit = grp_hit && (addr[27:24] == 4'h0);
        end
    end

    // A 16 MB board wraps inside its own memory even in a 32 MB group window.
    assign mem_off = {win32 & addr[24], addr[23:0]};
endmodule : vmesb_win_dec

// file: vmesb_slave.sv
// VME slave with data broadcasting, mode registers and block transfer support.
`timescale 1ns/1ps
module vmesb_slave
    import vmesb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [31:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [31:22] slave_base,
    input wire logic local_mem_32mb,
    input wire logic own_mst_cycle,
    input wire vmesb_vme_t vme_in,
    output logic [63:0] vme_dout,
    output logic vme_dout_oe_b,
    input wire logic vme_dtack_in,
    output logic vme_dtack_o,
    output logic vme_dtack_oe_b,
    input wire logic grp_in,
    output logic grp_o,
    output logic grp_oe_b,
    input wire logic size_in,
    output logic size_o,
    output logic size_oe_b,
    output vmesb_mem_t mem_out,
    input wire logic [63:0] mem_rdata,
    input wire logic mem_ack
);
    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    logic slv_en_r, slv_en_nxt, bc_en_r, bc_en_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    vmesb_state_t state_r, state_nxt;
    logic as_act_r, as_act_nxt, own_r, own_nxt, wr_r, wr_nxt;
    logic [5:0] am_r, am_nxt;
    logic [31:0] cur_addr_r, cur_addr_nxt;
    logic [8:0] beats_r, beats_nxt;
    logic is_grp_r, is_grp_nxt, grp_drv_r, grp_drv_nxt;
    logic [MEM_OFF_W-1:0] moff_r, moff_nxt;
    logic [63:0] wdata_r, wdata_nxt, dout_r, dout_nxt;
    logic blt32, blt64, blt, grp32, slv_hit, grp_hit, take;
    logic [MEM_OFF_W-1:0] mem_off;

    // -------------------------------------------------------------------------
    // Control registers
    // -------------------------------------------------------------------------
    // The mode register needs an exact data value so a stray byte store cannot
    // switch the slave; the broadcast switch decodes the address only.
    always_comb
    begin
        slv_en_nxt = slv_en_r;
        bc_en_nxt = bc_en_r;
        rdata_nxt = 8'h00;
        if (reg_wr && reg_addr == EXT_MODE_ADDR)
        begin
            if (reg_wdata == EXT_MODE_ON)
            begin
                slv_en_nxt = 1'b1;
            end
            else if (reg_wdata == EXT_MODE_OFF)
            begin
                slv_en_nxt = 1'b0;
            end
        end
        if (reg_wr && reg_addr == BCAST_ON_ADDR)
        begin
            bc_en_nxt = 1'b1;
        end
        if (reg_wr && reg_addr == BCAST_OFF_ADDR)
        begin
            bc_en_nxt = 1'b0;
        end
        if (reg_rd && reg_addr == EXT_MODE_ADDR)
        begin
            rdata_nxt = slv_en_r ? EXT_MODE_ON : EXT_MODE_OFF;
        end
        else if (reg_rd && reg_addr == STATUS_ADDR)
        begin
            rdata_nxt[ST_SLV_EN_BIT] = slv_en_r;
            rdata_nxt[ST_BC_EN_BIT] = bc_en_r;
            rdata_nxt[ST_GRP32_BIT] = grp32;
            rdata_nxt[ST_BUSY_BIT] = (state_r != ST_IDLE);
            rdata_nxt[ST_GRP_DRV_BIT] = grp_drv_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slv_en_r <= SLV_EN_RST;
            bc_en_r <= BC_EN_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            slv_en_r <= slv_en_nxt;
            bc_en_r <= bc_en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // -------------------------------------------------------------------------
    // Group size detection and decode
    // -------------------------------------------------------------------------
    // A 32 MB member pulls the shared size wire; any pull widens the window.
    assign grp32 = !size_in;
    assign size_o = 1'b0;
    assign size_oe_b = !(bc_en_r && local_mem_32mb);

    // The block mode is the master's choice, read from the address modifier.
    assign blt32 = (am_r == AM_BLT_USR) || (am_r == AM_BLT_SUP);
    assign blt64 = (am_r == AM_MBLT_USR) || (am_r == AM_MBLT_SUP);
    assign blt = blt32 || blt64;

    vmesb_win_dec u_dec (
        .addr(cur_addr_r),
        .slave_base(slave_base),
        .win32(local_mem_32mb),
        .grp32(grp32),
        .bc_en(bc_en_r),
        .write(wr_r),
        .slv_hit(slv_hit),
        .grp_hit(grp_hit),
        .mem_off(mem_off)
    );

    // Own window and group window are both live; a single cycle moves one
    // word, a block cycle up to the beat limit. Own-master cycles fall through
    // so another slave or the bus timer ends them.
    assign take = (state_r == ST_IDLE) && as_act_r && !vme_in.ds_b && slv_en_r
                  && !own_r && (slv_hit || grp_hit)
                  && (beats_r < MAX_BEATS) && (blt || beats_r == 9'h000);

    // -------------------------------------------------------------------------
    // Cycle sequencer
    // -------------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        as_act_nxt = as_act_r;
        own_nxt = own_r;
        wr_nxt = wr_r;
        am_nxt = am_r;
        cur_addr_nxt = cur_addr_r;
        beats_nxt = beats_r;
        is_grp_nxt = is_grp_r;
        grp_drv_nxt = grp_drv_r;
        moff_nxt = moff_r;
        wdata_nxt = wdata_r;
        dout_nxt = dout_r;
        // The address phase opens on the strobe's falling level.
        if (vme_in.as_b)
        begin
            as_act_nxt = 1'b0;
        end
        else if (!as_act_r)
        begin
            as_act_nxt = 1'b1;
            own_nxt = own_mst_cycle;
            wr_nxt = !vme_in.write_b;
            am_nxt = vme_in.am;
            cur_addr_nxt = vme_in.addr;
            beats_nxt = 9'h000;
        end
        unique case (state_r)
            ST_IDLE:
            begin
                if (take)
                begin
                    state_nxt = ST_MEM;
                    is_grp_nxt = grp_hit && !slv_hit;
                    grp_drv_nxt = grp_hit && !slv_hit;
                    moff_nxt = mem_off;
                    wdata_nxt = vme_in.data;
                end
            end
            ST_MEM:
            begin
                if (mem_ack)
                begin
                    dout_nxt = mem_rdata;
                    grp_drv_nxt = 1'b0;
                    state_nxt = is_grp_r ? ST_GRP : ST_ACK;
                end
            end
            ST_GRP:
            begin
                // Wait until no member holds the wire any more.
                if (grp_in)
                begin
                    state_nxt = ST_ACK;
                end
            end
            ST_ACK:
            begin
                if (vme_in.ds_b)
                begin
                    state_nxt = ST_IDLE;
                    beats_nxt = beats_r + 9'h001;
                    if (blt64)
                    begin
                        cur_addr_nxt = cur_addr_r + ADDR_STEP_D64;
                    end
                    else if (blt32)
                    begin
                        cur_addr_nxt = cur_addr_r + ADDR_STEP_D32;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            as_act_r <= 1'b0;
            own_r <= 1'b0;
            wr_r <= 1'b0;
            am_r <= 6'h00;
            cur_addr_r <= 32'h0000_0000;
            beats_r <= 9'h000;
            is_grp_r <= 1'b0;
            grp_drv_r <= 1'b0;
            moff_r <= '0;
            wdata_r <= 64'h0;
            dout_r <= 64'h0;
        end
        else
        begin
            state_r <= state_nxt;
            as_act_r <= as_act_nxt;
            own_r <= own_nxt;
            wr_r <= wr_nxt;
            am_r <= am_nxt;
            cur_addr_r <= cur_addr_nxt;
            beats_r <= beats_nxt;
            is_grp_r <= is_grp_nxt;
            grp_drv_r <= grp_drv_nxt;
            moff_r <= moff_nxt;
            wdata_r <= wdata_nxt;
            dout_r <= dout_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Pin and memory outputs
    // -------------------------------------------------------------------------
    // Open-collector style pins: the level is always low, the enable decides.
    assign vme_dtack_o = 1'b0;
    assign vme_dtack_oe_b = (state_r != ST_ACK);
    assign grp_o = 1'b0;
    assign grp_oe_b = !grp_drv_r;
    assign vme_dout = dout_r;
    assign vme_dout_oe_b = !((state_r == ST_ACK) && !wr_r);
    assign mem_out.req = (state_r == ST_MEM);
    assign mem_out.we = wr_r;
    assign mem_out.wide = blt64;
    assign mem_out.addr = moff_r;
    assign mem_out.wdata = wdata_r;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    chk_mode_bad_data: assert property (
        reg_wr && reg_addr == EXT_MODE_ADDR && reg_wdata != EXT_MODE_ON
        && reg_wdata != EXT_MODE_OFF |=> slv_en_r == $past(slv_en_r))
        else $error("Mode register changed on a wrong data value.");
    chk_mode_on_off: assert property (
        reg_wr && reg_addr == EXT_MODE_ADDR |=>
        slv_en_r == ($past(reg_wdata) == EXT_MODE_ON ? 1'b1 :
                     $past(reg_wdata) == EXT_MODE_OFF ? 1'b0 : $past(slv_en_r)))
        else $error("Slave enable did not follow the mode write.");
    chk_bcast_switch: assert property (
        reg_wr && reg_addr == BCAST_ON_ADDR |=> bc_en_r ##1 bc_en_r || $past(reg_wr))
        else $error("Broadcast enable was not set by its address.");
    chk_self_ignore: assert property (
        state_r == ST_IDLE && own_r && as_act_r |=> state_r == ST_IDLE)
        else $error("Slave answered its own master.");
    chk_grp_wait: assert property (
        state_r == ST_GRP && !grp_in |=> vme_dtack_oe_b)
        else $error("Acknowledge given while the group wire was held.");
    chk_grp_hold: assert property (
        state_r == ST_MEM && is_grp_r |-> !grp_oe_b)
        else $error("Group wire not held during a pending broadcast write.");
    chk_grp_off: assert property (
        !bc_en_r && $past(!bc_en_r) |-> grp_oe_b && !(take && grp_hit && !slv_hit))
        else $error("Group activity while broadcasting is off.");
    chk_blt64_step: assert property (
        state_r == ST_ACK && vme_in.ds_b && blt64 && !vme_in.as_b && as_act_r
        |=> cur_addr_r == $past(cur_addr_r) + ADDR_STEP_D64)
        else $error("Wide block address did not advance by eight.");
    chk_beat_limit: assert property (
        state_r == ST_IDLE && beats_r == MAX_BEATS |=> state_r == ST_IDLE)
        else $error("Beat taken past the block limit.");

    cov_broadcast: cover property (state_r == ST_GRP ##[1:50] state_r == ST_ACK);
    cov_blt64_burst: cover property (blt64 && beats_r == 9'h004);
    cov_own_window: cover property (take && slv_hit && bc_en_r);
    cov_other_ack: cover property (!vme_dtack_in && vme_dtack_oe_b && own_r);
endmodule : vmesb_slave

// file: vmesb_bus_model.sv
// Far-side model: bus wires with pull-ups, one peer group member and the local memory.
`timescale 1ns/1ps
module vmesb_bus_model
    import vmesb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic vme_dtack_o,
    input wire logic vme_dtack_oe_b,
    input wire logic grp_o,
    input wire logic grp_oe_b,
    input wire logic size_o,
    input wire logic size_oe_b,
    input wire vmesb_mem_t mem_out,
    input wire logic [3:0] mem_lat,
    input wire logic [5:0] peer_hold,
    input wire logic peer_32mb,
    output logic vme_dtack_in,
    output logic grp_in,
    output logic size_in,
    output logic mem_ack
);
    logic [3:0] lat_cnt;
    logic [5:0] peer_cnt;
    logic grp_hold_q;

    // -------------------------------------------------------------------------
    // Open-collector wires
    // -------------------------------------------------------------------------
    // Released lines float to the pull-up level, never to the last driven value.
    assign vme_dtack_in = vme_dtack_oe_b | vme_dtack_o;
    assign grp_in = (grp_oe_b | grp_o) & (peer_cnt == 6'h00);
    assign size_in = (size_oe_b | size_o) & ~peer_32mb;

    // The peer takes the same beat and holds the group wire for its own write time.
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lat_cnt <= 4'h0;
            mem_ack <= 1'b0;
            peer_cnt <= 6'h00;
            grp_hold_q <= 1'b0;
        end
        else
        begin
            grp_hold_q <= ~grp_oe_b;
            if (!grp_oe_b && !grp_hold_q)
                peer_cnt <= peer_hold;
            else if (peer_cnt != 6'h00)
                peer_cnt <= peer_cnt - 6'h01;
            if (mem_out.req && !mem_ack && lat_cnt >= mem_lat)
            begin
                mem_ack <= 1'b1;
                lat_cnt <= 4'h0;
            end
            else
            begin
                mem_ack <= 1'b0;
                if (mem_out.req && !mem_ack)
                    lat_cnt <= lat_cnt + 4'h1;
            end
        end
    end
endmodule : vmesb_bus_model

// file: vmesb_slave_test.sv
// Self-checking bench of the VME slave with group broadcasting.
`timescale 1ns/1ps
module vmesb_slave_test
    import vmesb_pkg::*;
();
    logic core_clk, rst_b, reg_wr, reg_rd, local_mem_32mb, own_mst_cycle, peer_32mb, grp_seen;
    logic [31:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    logic [31:22] slave_base;
    vmesb_vme_t vme_in;
    vmesb_mem_t mem_out, cap;
    logic [63:0] vme_dout, mem_rdata;
    logic vme_dout_oe_b, vme_dtack_in, vme_dtack_o, vme_dtack_oe_b, grp_in, grp_o, grp_oe_b;
    logic size_in, size_o, size_oe_b, mem_ack;
    logic [3:0] mem_lat;
    logic [5:0] peer_hold;
    logic [5:0] am_list [4] = '{AM_BLT_USR, AM_BLT_SUP, AM_MBLT_USR, AM_MBLT_SUP};
    integer seed;
    int n_mismatch, total_checks, last_lat;

    vmesb_slave uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .slave_base(slave_base), .local_mem_32mb(local_mem_32mb),
        .own_mst_cycle(own_mst_cycle), .vme_in(vme_in), .vme_dout(vme_dout),
        .vme_dout_oe_b(vme_dout_oe_b), .vme_dtack_in(vme_dtack_in), .vme_dtack_o(vme_dtack_o),
        .vme_dtack_oe_b(vme_dtack_oe_b), .grp_in(grp_in), .grp_o(grp_o), .grp_oe_b(grp_oe_b),
        .size_in(size_in), .size_o(size_o), .size_oe_b(size_oe_b), .mem_out(mem_out),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    vmesb_bus_model far (.core_clk(core_clk), .rst_b(rst_b), .vme_dtack_o(vme_dtack_o),
        .vme_dtack_oe_b(vme_dtack_oe_b), .grp_o(grp_o), .grp_oe_b(grp_oe_b), .size_o(size_o),
        .size_oe_b(size_oe_b), .mem_out(mem_out), .mem_lat(mem_lat), .peer_hold(peer_hold),
        .peer_32mb(peer_32mb), .vme_dtack_in(vme_dtack_in), .grp_in(grp_in),
        .size_in(size_in), .mem_ack(mem_ack));

    // -------------------------------------------------------------------------
    // Clock, monitors and helpers
    // -------------------------------------------------------------------------
    // Free-running 200 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Memory request is captured when it completes; group wire holding is noted.
    always @(posedge core_clk)
    begin
        if (mem_ack === 1'b1)
            cap <= mem_out;
        grp_seen <= (grp_seen === 1'b1) || (grp_oe_b === 1'b0);
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // Memory offset of a beat; boards of 16 MB wrap inside their memory.
    function automatic logic [MEM_OFF_W-1:0] exp_off(input logic [31:0] a, input int i,
                                                     input logic [31:0] step);
        logic [31:0] s;
        s = a + i * step;
        return {1'b0, s[23:0]};
    endfunction : exp_off

    task automatic reg_write(input logic [31:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [31:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // One address strobe with n beats; only the first n_ok beats may be acknowledged.
    task automatic vme_xfer(input logic [31:0] a, input logic [5:0] am, input logic we,
                            input logic own, input int n, input int n_ok);
        logic [31:0] step;
        logic [63:0] d, msk;
        int lat;
        step = (am == AM_MBLT_USR || am == AM_MBLT_SUP) ? ADDR_STEP_D64 :
               (am == AM_BLT_USR || am == AM_BLT_SUP) ? ADDR_STEP_D32 : 32'h0;
        msk = (step == ADDR_STEP_D64) ? '1 : 64'h0000_0000_ffff_ffff;
        @(posedge core_clk);
        vme_in.as_b <= 1'b0;
        vme_in.addr <= a;
        vme_in.am <= am;
        vme_in.write_b <= ~we;
        own_mst_cycle <= own;
        for (int i = 0; i < n; i++)
        begin
            d = {$random(seed), $random(seed)};
            @(posedge core_clk);
            vme_in.ds_b <= 1'b0;
            vme_in.data <= we ? d : ~vme_in.data;
            mem_rdata <= ~d;
            lat = 0;
            while (vme_dtack_in !== 1'b0 && lat < 40)
            begin
                @(posedge core_clk);
                lat++;
            end
            last_lat = lat;
            chk(lat < 40, i < n_ok);
            if (lat < 40 && i < n_ok)
            begin
                chk(cap.addr, exp_off(a, i, step));
                chk(cap.we, we);
                chk(cap.wide, step == ADDR_STEP_D64);
                chk((we ? cap.wdata : vme_dout) & msk, (we ? d : ~d) & msk);
                chk(we | vme_dout_oe_b, we);
            end
            vme_in.ds_b <= 1'b1;
            while (vme_dtack_in === 1'b0)
                @(posedge core_clk);
        end
        @(posedge core_clk);
        vme_in.as_b <= 1'b1;
        own_mst_cycle <= 1'b0;
        @(posedge core_clk);
    endtask : vme_xfer

    // Watchdog: the whole sequence needs under 5000 cycles, so 40000 means a hang.
    initial
    begin
        #(5 * 40000);
        n_mismatch++;
        final_report();
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        seed = 32'h97ee2416;
        rst_b = 1'b0;
        reg_addr = 32'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        vme_in = '0;
        vme_in.as_b = 1'b1;
        vme_in.ds_b = 1'b1;
        vme_in.write_b = 1'b1;
        slave_base = 10'h088;
        local_mem_32mb = 1'b0;
        own_mst_cycle = 1'b0;
        mem_rdata = 64'h0;
        mem_lat = 4'h1;
        peer_hold = 6'h00;
        peer_32mb = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        reg_read(EXT_MODE_ADDR, rd);
        chk(rd, EXT_MODE_OFF);
        reg_read(STATUS_ADDR, rd);
        chk(rd, 8'h00);
        vme_xfer(32'h2200_0010, 6'h09, 1'b1, 1'b0, 1, 0);
        reg_write(EXT_MODE_ADDR, 8'h05);
        reg_write(32'hfe38_4002, EXT_MODE_ON);
        reg_read(STATUS_ADDR, rd);
        chk(rd[ST_SLV_EN_BIT], 1'b0);
        reg_write(EXT_MODE_ADDR, EXT_MODE_ON);
        reg_read(EXT_MODE_ADDR, rd);
        chk(rd, EXT_MODE_ON);
        $display("Test modes done");
        // Random single cycles in the own window, both directions, varied memory delay.
        for (int k = 0; k < 16; k++)
        begin
            mem_lat <= 4'($random(seed) & 7);
            vme_xfer({8'h22, 24'($random(seed)) & 24'hfffff8}, 6'h09, 1'($random(seed)),
                     1'b0, 1, 1);
        end
        vme_xfer(32'h2200_0100, 6'h09, 1'b1, 1'b1, 1, 0);
        $display("Test own window done");
        foreach (am_list[j])
            vme_xfer(32'h2200_1000, am_list[j], 1'b1, 1'b0, 3, 3);
        vme_xfer(32'h2200_2000, AM_BLT_USR, 1'b1, 1'b0, 257, 256);
        vme_xfer(32'h2200_3000, 6'h09, 1'b1, 1'b0, 2, 1);
        $display("Test block done");
        vme_xfer(32'h2000_0040, 6'h09, 1'b1, 1'b0, 1, 0);
        chk(grp_seen, 1'b0);
        reg_write(BCAST_ON_ADDR, 8'($random(seed)));
        reg_read(STATUS_ADDR, rd);
        chk(rd[1:0], 2'b11);
        peer_hold <= 6'd20;
        vme_xfer(32'h2000_0040, 6'h09, 1'b1, 1'b0, 1, 1);
        chk(grp_seen, 1'b1);
        chk(last_lat >= 22, 1'b1);
        vme_xfer(32'h2000_0040, 6'h09, 1'b0, 1'b0, 1, 0);
        vme_xfer(32'h2200_0080, 6'h09, 1'b1, 1'b0, 1, 1);
        peer_32mb <= 1'b1;
        vme_xfer(32'h2100_0040, 6'h09, 1'b1, 1'b0, 1, 1);
        reg_read(STATUS_ADDR, rd);
        chk(rd[ST_GRP32_BIT], 1'b1);
        peer_32mb <= 1'b0;
        vme_xfer(32'h2100_0040, 6'h09, 1'b1, 1'b0, 1, 0);
        slave_base <= 10'h0c8;
        vme_xfer(32'h2000_0040, 6'h09, 1'b1, 1'b0, 1, 0);
        vme_xfer(32'h3000_0040, 6'h09, 1'b1, 1'b0, 1, 1);
        local_mem_32mb <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(size_oe_b, 1'b0);
        local_mem_32mb <= 1'b0;
        // A 16 MB group window must broadcast just like a 32 MB one.
        slave_base <= 10'h148;
        vme_xfer(32'h5000_0080, 6'h09, 1'b1, 1'b0, 1, 1);
        reg_write(BCAST_OFF_ADDR, 8'($random(seed)));
        vme_xfer(32'h5000_0040, 6'h09, 1'b1, 1'b0, 1, 0);
        $display("Test broadcast done");
        final_report();
    end
endmodule : vmesb_slave_test
